// ---- verilog/dwsd_pkg.sv ----
package dwsd_pkg;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int CMD_MSB    = 23;
  localparam int CMD_LSB    = 20;
  localparam int ADDR_MSB   = 19;
  localparam int ADDR_LSB   = 16;
  localparam int DATA_MSB   = 15;
  localparam int WIPER_BITS = 10;
  localparam int USER_WORDS = 13;
  localparam int USER_BASE  = 2;
  localparam int CNT_BITS   = 5;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP     = 4'h0;
  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_SAVE    = 4'h2;
  localparam logic [3:0] CMD_USTORE  = 4'h3;
  localparam logic [3:0] CMD_NVREAD  = 4'h9;
  localparam logic [3:0] CMD_WREAD   = 4'hA;
  localparam logic [3:0] CMD_WRITE   = 4'hB;
  localparam logic [3:0] CMD_SHL     = 4'hC;
  localparam logic [3:0] CMD_INC     = 4'hE;

  // ----------------------------------------------------------------------
  // Full-scale code and reset values
  // ----------------------------------------------------------------------
  localparam logic [9:0]  WIPER_FULL  = 10'h3FF;
  localparam logic [9:0]  NV_RESET    = 10'h200;
  localparam logic [15:0] USER_RESET  = 16'h0000;
  localparam logic [23:0] FRAME_RESET = 24'h000000;

endpackage

// ---- verilog/dwsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one asynchronous level.
module dwsd_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------
  // The first flop feeds only the second one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/dwsd_decoder.sv ----
// How it works
// - Command B loads wiper from data bits.
// - A 24-clock frame shifts out a full 24-bit word.
// - Command E ch0 adds one to wiper.
// - Command 2 saves wiper to nonvolatile word.
// - Write-protect low blocks nonvolatile changes.
// - Command 1 ch0 restores wiper from store.
// - Power-on and preset pin restore both wipers.
// - Command C doubles addressed wiper.
// - Doubling saturates at full scale 0x3FF.
// - Command 3 stores data into user word.
// - Thirteen sixteen-bit user words are addressable.
// - Command 9 prepares user word readback.
// - Read output: command byte, then data.
// - No-op after read clocks data out.
// - Command A ch0 prepares wiper readback.
// - Each wiper holds a ten-bit tap code.
// - User words stored and read by commands.
// - Restore leaves read power until no-op.
`timescale 1ns/1ps
`default_nettype none

module dwsd_decoder
  import dwsd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output var  logic        sdo,
  input  wire logic        preset_restore_pin_n,
  input  wire logic        write_protect_n,
  output var  logic [9:0]  wiper_setting_ch0,
  output var  logic [9:0]  wiper_setting_ch1,
  output var  logic        read_power_mode
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [4:0] pin_async;
  logic [4:0] pin_sync;

  assign pin_async = {write_protect_n, preset_restore_pin_n, sdi, cs_n, sclk};

  // One synchroniser per outside pin.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      dwsd_sync u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (pin_async[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic pr_n_s;
  logic wp_n_s;

  assign sclk_s = pin_sync[0];
  assign cs_n_s = pin_sync[1];
  assign sdi_s  = pin_sync[2];
  assign pr_n_s = pin_sync[3];
  assign wp_n_s = pin_sync[4];

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  logic sclk_q;
  logic cs_n_q;
  logic pr_n_q;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_end;
  logic pr_rise;

  // Delayed copies of the synchronised clock, select and preset pins for edge finding.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      pr_n_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      pr_n_q <= pr_n_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_q & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_n_q;
  assign pr_rise   = pr_n_s & ~pr_n_q;

  // ----------------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------------
  logic [23:0]         rx_q;
  logic [CNT_BITS-1:0] bit_cnt_q;
  logic                frame_ok;

  // Bits enter at the bottom, so the first bit lands in the command nibble.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_q      <= FRAME_RESET;
      bit_cnt_q <= '0;
    end else if (frame_end) begin
      bit_cnt_q <= '0;
    end else if (sclk_rise) begin
      rx_q      <= {rx_q[22:0], sdi_s};
      // The count parks at all ones, so an overlong frame never looks complete.
      if (bit_cnt_q != {CNT_BITS{1'b1}}) begin
        bit_cnt_q <= bit_cnt_q + CNT_BITS'(1);
      end
    end
  end

  // Only a frame of exactly 24 clocks is executed.
  assign frame_ok = frame_end && (bit_cnt_q == CNT_BITS'(FRAME_BITS));

  logic [3:0]  cmd;
  logic [3:0]  addr;
  logic [15:0] data;

  assign cmd  = rx_q[CMD_MSB:CMD_LSB];
  assign addr = rx_q[ADDR_MSB:ADDR_LSB];
  assign data = rx_q[DATA_MSB:0];

  // ----------------------------------------------------------------------
  // Nonvolatile store
  // ----------------------------------------------------------------------
  logic [9:0]  saved_wiper_ch0;
  logic [9:0]  saved_wiper_ch1;
  logic [15:0] user_q [USER_WORDS];
  logic        nv_wr_ok;

  assign nv_wr_ok = frame_ok && wp_n_s;

  // Saved wiper words, written by the save command.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      saved_wiper_ch0 <= NV_RESET;
      saved_wiper_ch1 <= NV_RESET;
    end else if (nv_wr_ok && cmd == CMD_SAVE) begin
      if (addr == 4'h0) begin
        saved_wiper_ch0 <= wiper_setting_ch0;
      end else if (addr == 4'h1) begin
        saved_wiper_ch1 <= wiper_setting_ch1;
      end
    end
  end

  // User words, one per address from 2 upward.
  genvar ui;
  generate
    for (ui = 0; ui < USER_WORDS; ui++) begin : g_user
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          user_q[ui] <= USER_RESET;
        end else if (nv_wr_ok && cmd == CMD_USTORE &&
                     addr == 4'(ui + USER_BASE)) begin
          user_q[ui] <= data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Wiper registers
  // ----------------------------------------------------------------------
  logic       boot_q;
  logic [9:0] wiper_sel;
  logic [9:0] wiper_shl;

  assign wiper_sel = (addr == 4'h1) ? wiper_setting_ch1 : wiper_setting_ch0;
  assign wiper_shl = wiper_sel[9] ? WIPER_FULL : {wiper_sel[8:0], 1'b0};

  // Flags the first cycle after reset release for the power-on restore.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_q <= 1'b1;
    end else begin
      boot_q <= 1'b0;
    end
  end

  // Both channels follow the same command set, differing by address.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wiper_setting_ch0 <= '0;
      wiper_setting_ch1 <= '0;
    end else if (boot_q || pr_rise) begin
      wiper_setting_ch0 <= saved_wiper_ch0;
      wiper_setting_ch1 <= saved_wiper_ch1;
    end else if (frame_ok && addr == 4'h0) begin
      unique case (cmd)
        CMD_WRITE:   wiper_setting_ch0 <= data[WIPER_BITS-1:0];
        CMD_INC:     wiper_setting_ch0 <= wiper_setting_ch0 + 10'h001;
        CMD_SHL:     wiper_setting_ch0 <= wiper_shl;
        CMD_RESTORE: wiper_setting_ch0 <= saved_wiper_ch0;
        default:     wiper_setting_ch0 <= wiper_setting_ch0;
      endcase
    end else if (frame_ok && addr == 4'h1) begin
      unique case (cmd)
        CMD_WRITE:   wiper_setting_ch1 <= data[WIPER_BITS-1:0];
        CMD_INC:     wiper_setting_ch1 <= wiper_setting_ch1 + 10'h001;
        CMD_SHL:     wiper_setting_ch1 <= wiper_shl;
        CMD_RESTORE: wiper_setting_ch1 <= saved_wiper_ch1;
        default:     wiper_setting_ch1 <= wiper_setting_ch1;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read power state
  // ----------------------------------------------------------------------
  // Restore and read commands raise it, a no-op frame drops it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_power_mode <= 1'b0;
    end else if (frame_ok) begin
      if (cmd == CMD_RESTORE || cmd == CMD_NVREAD || cmd == CMD_WREAD) begin
        read_power_mode <= 1'b1;
      end else if (cmd == CMD_NOP) begin
        read_power_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit word
  // ----------------------------------------------------------------------
  logic [23:0] reply_d;
  logic [23:0] tx_q;
  logic [3:0]  uidx;

  assign uidx = addr - 4'(USER_BASE);

  // Next frame's word: echo, or command byte plus fetched contents.
  always_comb begin
    reply_d = rx_q;
    if (cmd == CMD_NVREAD && addr >= 4'(USER_BASE) &&
        uidx < 4'(USER_WORDS)) begin
      reply_d = {rx_q[23:16], user_q[uidx]};
    end else if (cmd == CMD_NVREAD && addr == 4'h0) begin
      reply_d = {rx_q[23:16], 6'h00, saved_wiper_ch0};
    end else if (cmd == CMD_NVREAD && addr == 4'h1) begin
      reply_d = {rx_q[23:16], 6'h00, saved_wiper_ch1};
    end else if (cmd == CMD_WREAD) begin
      reply_d = {rx_q[23:16], 6'h00, wiper_sel};
    end
  end

  // Loaded at frame end, shifted out MSB first on falling edges.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= FRAME_RESET;
    end else if (frame_end) begin
      tx_q <= frame_ok ? reply_d : rx_q;
    end else if (sclk_fall) begin
      tx_q <= {tx_q[22:0], 1'b0};
    end
  end

  // Output bit register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo <= 1'b0;
    end else begin
      sdo <= tx_q[23];
    end
  end

endmodule

`default_nettype wire

// ---- verification/dwsd_decoder_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module dwsd_decoder_monitor
  import dwsd_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       sdi,
  input wire logic       sdo,
  input wire logic       preset_restore_pin_n,
  input wire logic       write_protect_n,
  input wire logic [9:0] wiper_setting_ch0,
  input wire logic [9:0] wiper_setting_ch1,
  input wire logic       read_power_mode
);
  logic        sc_q;
  logic [23:0] sh_q;
  logic [4:0]  n_q;
  logic [9:0]  w0_q;

  // Rebuilds the received frame and its bit count from the pins.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_q <= 1'b0;
      sh_q <= 24'h000000;
      n_q  <= 5'h00;
    end else begin
      sc_q <= sclk;
      if (cs_n) n_q <= 5'h00;
      else if (sclk && !sc_q) begin
        sh_q <= {sh_q[22:0], sdi};
        n_q  <= n_q + 5'h01;
      end
    end
  end

  // Holds the first wiper as it stood when the frame closed.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) w0_q <= 10'h000;
    else if (!cs_n) w0_q <= wiper_setting_ch0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_frame;
    $rose(cs_n) && n_q == 5'h18;
  endsequence

  a_write_ch_zero: assert property (s_frame ##0 sh_q[23:16] == 8'hB0 |-> ##[2:8]
    wiper_setting_ch0 == sh_q[9:0]) else $error("first wiper not loaded");
  a_write_ch_one: assert property (s_frame ##0 sh_q[23:16] == 8'hB1 |-> ##[2:8]
    wiper_setting_ch1 == sh_q[9:0]) else $error("second wiper not loaded");
  a_step_up_one: assert property (s_frame ##0 sh_q[23:16] == 8'hE0 |-> ##[2:8]
    wiper_setting_ch0 == w0_q + 10'h001) else $error("increment wrong");
  a_double_sat: assert property (s_frame ##0 sh_q[23:16] == 8'hC0 |-> ##[2:8]
    wiper_setting_ch0 == (w0_q[9] ? WIPER_FULL : {w0_q[8:0], 1'b0}))
    else $error("doubling wrong");
  a_nop_idle: assert property (s_frame ##0 sh_q[23:20] == 4'h0 |-> ##[2:8]
    !read_power_mode) else $error("read power not left");
  a_wiper_quiet: assert property ((!cs_n && preset_restore_pin_n)[*8] |->
    $stable(wiper_setting_ch0) && $stable(wiper_setting_ch1)) else $error("wiper moved");
  a_sdo_steady: assert property ((!cs_n && sclk)[*4] |-> $stable(sdo))
    else $error("serial output moved while clock high");
  a_short_ignored: assert property ($rose(cs_n) && n_q != 5'h18 && n_q != 5'h00 |=>
    ($stable(wiper_setting_ch0) && $stable(wiper_setting_ch1))[*6])
    else $error("short frame acted on");
endmodule

bind dwsd_decoder dwsd_decoder_monitor u_mon (.clk(clk), .reset_n(reset_n), .sclk(sclk),
  .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .preset_restore_pin_n(preset_restore_pin_n),
  .write_protect_n(write_protect_n), .wiper_setting_ch0(wiper_setting_ch0),
  .wiper_setting_ch1(wiper_setting_ch1), .read_power_mode(read_power_mode));

`default_nettype wire

// ---- verification/dwsd_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module dwsd_host (
  input  wire logic clk,
  input  wire logic sdo,
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic sdi
);
  // Idle bus: clock parked low, device not selected.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // Sends nb bits of w and gathers the reply; the clock is 8 system cycles.
  task automatic xfer(input logic [23:0] w, input int nb, output logic [23:0] r);
    r = 24'h000000;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      sdi = (i >= 0) ? w[i] : 1'b0;
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      r = {r[22:0], sdo};
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    sdi  = ~sdi;
    repeat (10) @(negedge clk);
  endtask
endmodule

`default_nettype wire

// ---- verification/dwsd_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module dwsd_decoder_test;
  import dwsd_pkg::*;
  logic        clk, reset_n, preset_n, wp_n, sclk, cs_n, sdi, sdo, rpm, ch;
  logic [9:0]  w0, w1;
  logic [23:0] nxt, r;
  logic [31:0] d;
  int          err_total, n_compared;

  dwsd_decoder uut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .preset_restore_pin_n(preset_n), .write_protect_n(wp_n),
    .wiper_setting_ch0(w0), .wiper_setting_ch1(w1), .read_power_mode(rpm));
  dwsd_host host (.clk(clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  // System clock of 100 ns.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk_word(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [9:0] dbl(input logic [9:0] v);
    return v[9] ? WIPER_FULL : {v[8:0], 1'b0};
  endfunction

  // One full frame; the reply must be the word the bench expects.
  task automatic fr(input logic [23:0] w);
    host.xfer(w, 24, r);
    chk_word("reply", nxt, r);
    nxt = w;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude;
  end

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    preset_n = 1'b1;
    wp_n = 1'b1;
    nxt = FRAME_RESET;
    err_total = 0;
    n_compared = 0;
    void'($urandom(77813));
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (5) @(negedge clk);
    chk_word("ch0", 24'(NV_RESET), 24'(w0));
    fr(24'hB00100);
    chk_word("ch0", 24'h000100, 24'(w0));
    fr(24'hB10200);
    chk_word("ch1", 24'h000200, 24'(w1));
    fr(24'hE0A5C3);
    fr(24'hE0125A);
    chk_word("ch0", 24'h000102, 24'(w0));
    fr(24'h20F00F);
    fr(24'hB003FF);
    fr(24'h10ABCD);
    chk_word("ch0", 24'h000102, 24'(w0));
    chk_bit("rpm", 1'b1, rpm);
    fr(24'h000000);
    chk_bit("rpm", 1'b0, rpm);
    wp_n = 1'b0;
    fr(24'hB00155);
    fr(24'hB10155);
    fr(24'h200000);
    wp_n = 1'b1;
    preset_n = 1'b0;
    repeat (5) @(negedge clk);
    preset_n = 1'b1;
    repeat (10) @(negedge clk);
    chk_word("ch0", 24'h000102, 24'(w0));
    chk_word("ch1", 24'(NV_RESET), 24'(w1));
    fr(24'hB00200);
    fr(24'hC07E11);
    chk_word("ch0", 24'(WIPER_FULL), 24'(w0));
    fr(24'hA05A5A);
    nxt = 24'hA003FF;
    fr(24'h32AAAA);
    fr(24'h335555);
    wp_n = 1'b0;
    fr(24'h321234);
    wp_n = 1'b1;
    fr(24'h920F0F);
    nxt = 24'h92AAAA;
    fr(24'h930000);
    nxt = 24'h935555;
    fr(24'h3E1357);
    fr(24'h9E0000);
    chk_bit("rpm", 1'b1, rpm);
    nxt = 24'h9E1357;
    fr(24'h000000);
    chk_bit("rpm", 1'b0, rpm);
    host.xfer(24'hB00000, 16, r);
    chk_word("ch0", 24'(WIPER_FULL), 24'(w0));
    host.xfer(24'hB00000, 25, r);
    chk_word("ch0", 24'(WIPER_FULL), 24'(w0));
    host.xfer(24'h000000, 24, r);
    nxt = 24'h000000;
    for (int k = 0; k < 6; k++) begin
      d = $urandom;
      ch = d[31];
      fr({7'h58, ch, d[15:0]});
      chk_word("wiper", 24'(d[9:0]), 24'(ch ? w1 : w0));
      fr({7'h60, ch, d[27:12]});
      chk_word("wiper", 24'(dbl(d[9:0])), 24'(ch ? w1 : w0));
    end
    conclude;
  end
endmodule

`default_nettype wire
